//--- mts_sync.sv
// Purpose: Reads an external SSI multiturn value and keeps a 24-bit turn counter in step with it.
// Assumes: Singleturn wrap pulses and position MSBs come from logic on hclk.
`timescale 1ns/1ps
`include "mts_cfg.svh"

module mts_sync #(
	parameter int VERIFY_CYCLES = `MTS_VERIFY_CYC,
	parameter int GAP_CYCLES = `MTS_GAP_CYC
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Singleturn side
	input wire logic st_wrap_up,
	input wire logic st_wrap_down,
	input wire logic [3:0] st_position_msbs,
	// SSI link to the multiturn sensor
	output logic ssi_clk,
	input wire logic ssi_data,
	// Results
	output logic [23:0] turn_count,
	output logic [5:0] st_extension,
	output logic [2:0] st_extension_width,
	output logic startup_done,
	output logic irq
);
	import mts_pkg::*;

	if (VERIFY_CYCLES < 1 || GAP_CYCLES < 1 || GAP_CYCLES > 65535) begin : g_bad_param
		$error("mts_sync: timing parameter out of range");
	end

	localparam logic [7:0] HALF = 8'(`MTS_SSI_HALF_CYC);

	// ----------------------------------------
	// Decoding helpers
	// ----------------------------------------
	function automatic logic [4:0] mt_bits_f(input logic [3:0] m);
		unique case (m)
			4'hB: mt_bits_f = 5'd4;
			4'hC: mt_bits_f = 5'd8;
			4'hD: mt_bits_f = 5'd12;
			4'hE: mt_bits_f = 5'd16;
			4'hF: mt_bits_f = 5'd18;
			4'h7, 4'h8, 4'h9, 4'hA: mt_bits_f = 5'd12;
			default: mt_bits_f = 5'd0;
		endcase
	endfunction : mt_bits_f

	function automatic logic [2:0] st_bits_f(input logic [3:0] m);
		if (m >= 4'h1 && m <= 4'h6) begin
			st_bits_f = m[2:0];
		end else if (m >= 4'h7 && m <= 4'hA) begin
			st_bits_f = 3'(m - 4'h4);
		end else begin
			st_bits_f = 3'd0;
		end
	endfunction : st_bits_f

	function automatic logic has_err_f(input logic [1:0] e);
		has_err_f = (e == 2'h1) || (e == 2'h3);
	endfunction : has_err_f

	function automatic logic [23:0] mask_f(input logic [4:0] n);
		mask_f = 24'((25'h1 << n) - 25'h1);
	endfunction : mask_f

	// ----------------------------------------
	// Bus slave
	// ----------------------------------------
	mts_cfg_type cfg;
	mts_req_type req;
	logic wr_pend;
	logic [2:0] status;
	logic [2:0] mask;
	logic [23:0] count;
	logic started;
	logic verify_pend;
	logic [31:0] rd_mux;
	logic ahb_take;
	logic cmd_verify;
	logic restart;

	assign ahb_take = hsel && htrans[1] && hready;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign cmd_verify = wr_pend && req.addr == `MTS_ADDR_CMD && hwdata[`MTS_CMD_VERIFY];
	// Leaving mode zero restarts the startup read, otherwise the reset default would skip it for good.
	assign restart = wr_pend && req.addr == `MTS_ADDR_MODE && started && cfg.mode == 4'h0
		&& hwdata[`MTS_MODE_LSB +: 4] != 4'h0;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			req <= '0;
		end else begin
			wr_pend <= ahb_take && hwrite;
			req <= '{write: hwrite, addr: haddr[9:0]};
		end
	end

	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (haddr[9:0])
			`MTS_ADDR_DIR: rd_mux = {24'h00_0000, cfg.esel, cfg.inv, 5'h00};
			`MTS_ADDR_OFF: rd_mux = {24'h00_0000, cfg.off, 4'h0};
			`MTS_ADDR_MODE: rd_mux = {24'h00_0000, 1'b0, cfg.chk, cfg.sbl, cfg.mode};
			`MTS_ADDR_STAT: rd_mux = {29'h0000_0000, status};
			`MTS_ADDR_MASK: rd_mux = {29'h0000_0000, mask};
			`MTS_ADDR_CNT: rd_mux = {8'h00, count};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// Read data is captured at the address phase so it leaves a flip-flop with no wait state.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (ahb_take && !hwrite) begin
			hrdata <= rd_mux;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg <= `MTS_CFG_RST;
			mask <= `MTS_MASK_RST;
		end else if (wr_pend) begin
			unique case (req.addr)
				`MTS_ADDR_DIR: begin
					cfg.inv <= hwdata[`MTS_INV_BIT];
					cfg.esel <= hwdata[`MTS_ESEL_LSB +: 2];
				end
				`MTS_ADDR_OFF: cfg.off <= hwdata[`MTS_OFF_LSB +: 4];
				`MTS_ADDR_MODE: begin
					cfg.mode <= hwdata[`MTS_MODE_LSB +: 4];
					cfg.sbl <= hwdata[`MTS_SBL_LSB +: 2];
					cfg.chk <= hwdata[`MTS_CHK_BIT];
				end
				`MTS_ADDR_MASK: mask <= hwdata[2:0];
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// SSI link
	// ----------------------------------------
	mts_link_type lnk;
	logic data_meta;
	logic data_sync;
	logic [7:0] div_cnt;
	logic [15:0] gap_cnt;
	logic [4:0] bit_cnt;
	logic [23:0] shift;
	logic frame_done;
	logic start_req;
	logic [4:0] flen;
	logic [4:0] dlen;
	logic [2:0] sync_n;

	assign sync_n = {1'b0, cfg.sbl} + 3'd1;
	assign dlen = mt_bits_f(cfg.mode) + 5'(st_bits_f(cfg.mode)) + 5'(sync_n);
	assign flen = dlen + 5'(has_err_f(cfg.esel));
	// Mode zero never starts a frame; a failed startup read keeps asking.
	assign start_req = lnk == LNK_IDLE && cfg.mode != 4'h0 && (!started || verify_pend);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			data_meta <= 1'b0;
			data_sync <= 1'b0;
		end else begin
			data_meta <= ssi_data;
			data_sync <= data_meta;
		end
	end

	// The clock idles high; each bit is a low half then a high half, sampled at the end of the high half.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lnk <= LNK_IDLE;
			ssi_clk <= 1'b1;
			div_cnt <= 8'h00;
			gap_cnt <= 16'h0000;
			bit_cnt <= 5'h00;
			shift <= 24'h00_0000;
			frame_done <= 1'b0;
		end else begin
			frame_done <= 1'b0;
			unique case (lnk)
				LNK_IDLE: begin
					if (start_req) begin
						lnk <= LNK_LOW;
						ssi_clk <= 1'b0;
						div_cnt <= HALF - 8'h01;
						bit_cnt <= flen;
						shift <= 24'h00_0000;
					end
				end
				LNK_LOW: begin
					if (div_cnt == 8'h00) begin
						lnk <= LNK_HIGH;
						ssi_clk <= 1'b1;
						div_cnt <= HALF - 8'h01;
					end else begin
						div_cnt <= div_cnt - 8'h01;
					end
				end
				LNK_HIGH: begin
					if (div_cnt == 8'h00) begin
						shift <= {shift[22:0], data_sync};
						bit_cnt <= bit_cnt - 5'h01;
						if (bit_cnt == 5'h01) begin
							lnk <= LNK_GAP;
							gap_cnt <= 16'(GAP_CYCLES - 1);
							frame_done <= 1'b1;
						end else begin
							lnk <= LNK_LOW;
							ssi_clk <= 1'b0;
							div_cnt <= HALF - 8'h01;
						end
					end else begin
						div_cnt <= div_cnt - 8'h01;
					end
				end
				LNK_GAP: begin
					if (gap_cnt == 16'h0000) begin
						lnk <= LNK_IDLE;
					end else begin
						gap_cnt <= gap_cnt - 16'h0001;
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// Frame evaluation and synchronization
	// ----------------------------------------
	logic rd_err;
	logic [23:0] word;
	logic [23:0] word_adj;
	logic [3:0] st_top;
	logic [3:0] ext_sync;
	logic [4:0] diff;
	logic [23:0] sync_val;
	logic [23:0] sync_mask;

	assign sync_mask = mask_f(5'(sync_n));

	always_comb begin
		rd_err = (cfg.esel == 2'h1 && !shift[0]) || (cfg.esel == 2'h3 && shift[0]);
		word = has_err_f(cfg.esel) ? {1'b0, shift[23:1]} : shift;
		if (cfg.inv) begin
			word = ~word & mask_f(dlen);
		end
		word_adj = (word + {{20{cfg.off[3]}}, cfg.off}) & mask_f(dlen);
		st_top = st_position_msbs >> (3'd4 - sync_n);
		ext_sync = word_adj[3:0] & sync_mask[3:0];
		// Phase difference taken modulo the overlap, then read as signed.
		diff = 5'((st_top - ext_sync) & sync_mask[3:0]);
		if (diff[3:0] >= (4'h1 << (sync_n - 3'd1))) begin
			diff = diff - 5'(5'h1 << sync_n);
		end
		sync_val = (word_adj + {{19{diff[4]}}, diff}) >> sync_n;
	end

	// ----------------------------------------
	// Turn counter and verification
	// ----------------------------------------
	logic [31:0] vtimer;
	logic timer_hit;

	assign timer_hit = cfg.chk && started && vtimer == 32'(VERIFY_CYCLES - 1);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count <= 24'h00_0000;
			started <= 1'b0;
		end else if (restart) begin
			started <= 1'b0;
		end else if (!started && cfg.mode == 4'h0) begin
			started <= 1'b1;
		end else if (frame_done && !started && !rd_err) begin
			count <= sync_val;
			started <= 1'b1;
		end else if (started && st_wrap_up && !st_wrap_down) begin
			count <= count + 24'h00_0001;
		end else if (started && st_wrap_down && !st_wrap_up) begin
			count <= count - 24'h00_0001;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			vtimer <= 32'h0000_0000;
		end else if (!cfg.chk || timer_hit) begin
			vtimer <= 32'h0000_0000;
		end else begin
			vtimer <= vtimer + 32'h0000_0001;
		end
	end

	// A new trigger in the cycle the pending request is taken keeps it pending.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			verify_pend <= 1'b0;
		end else if (timer_hit || cmd_verify) begin
			verify_pend <= 1'b1;
		end else if (start_req && started) begin
			verify_pend <= 1'b0;
		end
	end

	// ----------------------------------------
	// Status and interrupt
	// ----------------------------------------
	logic [2:0] events;
	logic [2:0] w1c;

	assign events[`MTS_ST_MISMATCH] = frame_done && started && !rd_err && sync_val != count;
	assign events[`MTS_ST_RDERR] = frame_done && rd_err;
	assign events[`MTS_ST_READY] = !started && ((frame_done && !rd_err) || cfg.mode == 4'h0);
	assign w1c = (wr_pend && req.addr == `MTS_ADDR_STAT) ? hwdata[2:0] : 3'h0;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status <= `MTS_STAT_RST;
		end else begin
			status <= (status & ~w1c) | events;
		end
	end

	assign irq = |(status & mask);

	logic [23:0] ext_mask;

	assign ext_mask = mask_f(5'(st_bits_f(cfg.mode)));

	// Outputs are registered so downstream sees stable data.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			turn_count <= 24'h00_0000;
			st_extension <= 6'h00;
			st_extension_width <= 3'h0;
			startup_done <= 1'b0;
		end else begin
			turn_count <= count;
			st_extension <= count[5:0] & ext_mask[5:0];
			st_extension_width <= st_bits_f(cfg.mode);
			startup_done <= started;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	property p_startup_load;
		frame_done && !started && !rd_err |=> started && count == $past(sync_val);
	endproperty
	a_startup_load: assert property (p_startup_load) else $error("startup value not loaded");

	property p_count_up;
		started && st_wrap_up && !st_wrap_down && !restart |=> count == $past(count) + 24'h00_0001;
	endproperty
	a_count_up: assert property (p_count_up) else $error("counter missed a wrap");

	property p_retry;
		lnk == LNK_IDLE && !started && cfg.mode != 4'h0 |=> lnk == LNK_LOW;
	endproperty
	a_retry: assert property (p_retry) else $error("failed startup read not repeated");

	property p_mode0_silent;
		cfg.mode == 4'h0 && lnk == LNK_IDLE |=> lnk == LNK_IDLE && ssi_clk;
	endproperty
	a_mode0_silent: assert property (p_mode0_silent) else $error("frame started in mode zero");

	property p_frame_len;
		start_req |=> bit_cnt == $past(flen) && !ssi_clk;
	endproperty
	a_frame_len: assert property (p_frame_len) else $error("wrong frame length");

	property p_err_high;
		frame_done && cfg.esel == 2'h3 && shift[0] |=> status[`MTS_ST_RDERR];
	endproperty
	a_err_high: assert property (p_err_high) else $error("high error bit not flagged");

	property p_mismatch;
		frame_done && started && !rd_err && sync_val != count |=> status[`MTS_ST_MISMATCH];
	endproperty
	a_mismatch: assert property (p_mismatch) else $error("mismatch not flagged");

	property p_verify_cmd;
		cmd_verify && started && cfg.mode != 4'h0 && lnk == LNK_IDLE |-> ##2 lnk == LNK_LOW;
	endproperty
	a_verify_cmd: assert property (p_verify_cmd) else $error("verify command ignored");

	property p_half_period;
		$fell(ssi_clk) |-> !ssi_clk [*8];
	endproperty
	a_half_period: assert property (p_half_period) else $error("ssi clock low phase too short");

	c_startup: cover property (frame_done && !started && !rd_err);
	c_retry: cover property (frame_done && !started && rd_err);
	c_mismatch: cover property (events[`MTS_ST_MISMATCH]);
	c_periodic: cover property (timer_hit);

endmodule : mts_sync

//--- mts_cfg.svh
// Purpose: Offsets, field positions, reset values and timing counts of the multiturn reader.
// Assumes: 32-bit AHB-Lite words, one register per aligned word, byte address = index * 4.
// Notes: Only definitions live here.
`ifndef MTS_CFG_SVH
`define MTS_CFG_SVH

// ----------------------------------------
// Register indices and byte addresses
// ----------------------------------------
`define MTS_IDX_DIR 10'h00E
`define MTS_IDX_OFF 10'h00F
`define MTS_IDX_MODE 10'h010
`define MTS_IDX_STAT 10'h020
`define MTS_IDX_MASK 10'h021
`define MTS_IDX_CMD 10'h022
`define MTS_IDX_CNT 10'h023
`define MTS_ADDR_DIR (`MTS_IDX_DIR * 10'h004)
`define MTS_ADDR_OFF (`MTS_IDX_OFF * 10'h004)
`define MTS_ADDR_MODE (`MTS_IDX_MODE * 10'h004)
`define MTS_ADDR_STAT (`MTS_IDX_STAT * 10'h004)
`define MTS_ADDR_MASK (`MTS_IDX_MASK * 10'h004)
`define MTS_ADDR_CMD (`MTS_IDX_CMD * 10'h004)
`define MTS_ADDR_CNT (`MTS_IDX_CNT * 10'h004)

// ----------------------------------------
// Field positions
// ----------------------------------------
`define MTS_INV_BIT 5
`define MTS_ESEL_LSB 6
`define MTS_OFF_LSB 4
`define MTS_MODE_LSB 0
`define MTS_SBL_LSB 4
`define MTS_CHK_BIT 6
`define MTS_ST_MISMATCH 0
`define MTS_ST_RDERR 1
`define MTS_ST_READY 2
`define MTS_CMD_VERIFY 0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define MTS_CFG_RST 14'h0000
`define MTS_STAT_RST 3'h0
`define MTS_MASK_RST 3'h0

// ----------------------------------------
// Timing
// ----------------------------------------
`define MTS_HCLK_NS 10
`define MTS_SSI_HALF_NS 80
`define MTS_SSI_HALF_CYC ((`MTS_SSI_HALF_NS + `MTS_HCLK_NS - 1) / `MTS_HCLK_NS)
`define MTS_GAP_NS 20000
`define MTS_GAP_CYC ((`MTS_GAP_NS + `MTS_HCLK_NS - 1) / `MTS_HCLK_NS)
`define MTS_VERIFY_NS 1000000
`define MTS_VERIFY_CYC (`MTS_VERIFY_NS / `MTS_HCLK_NS)

`endif

//--- mts_pkg.sv
// Purpose: Types shared by the multiturn reader.
// Assumes: Nothing beyond SystemVerilog.
// Notes: Numbers live in mts_cfg.svh.
package mts_pkg;

	typedef enum logic [1:0] {LNK_IDLE, LNK_LOW, LNK_HIGH, LNK_GAP} mts_link_type;

	typedef struct packed {
		logic [3:0] mode;
		logic [1:0] sbl;
		logic chk;
		logic inv;
		logic [1:0] esel;
		logic [3:0] off;
	} mts_cfg_type;

	typedef struct packed {
		logic write;
		logic [9:0] addr;
	} mts_req_type;

endpackage : mts_pkg

//--- mts_sensor.sv
// Purpose: Behavioural model of the external SSI turn-count sensor.
// Assumes: ssi_clk changes only on hclk edges; the bench sets frame word and length.
// Notes: A frame holds data bits and an optional error bit only.
`timescale 1ns/1ps

module mts_sensor (
	// Clocking
	input wire logic hclk,
	// Link
	input wire logic ssi_clk,
	output logic ssi_data,
	// Frame content from the bench
	input wire logic slow,
	input wire logic [31:0] word,
	input wire logic [5:0] len
);
	int hi = 0;
	int idx = 0;
	logic prev = 1'b1;

	initial ssi_data = 1'b1;

	// ----------------------------------------
	// Shift out on falling clock edges
	// ----------------------------------------
	always @(posedge hclk) begin
		prev <= ssi_clk;
		hi <= ssi_clk ? hi + 1 : 0;
		// A long high clock ends the frame; the released line then shows the inverse of the last bit.
		if (hi == 12) begin
			idx <= 0;
			ssi_data <= ~ssi_data;
		end
		// The slow answer lands half a low phase late, still well before the sampling point.
		if (prev && !ssi_clk && idx < len) begin
			ssi_data <= #(slow ? 40 : 1) word[len - 1 - idx];
			idx <= idx + 1;
		end
	end
endmodule : mts_sensor

//--- tb_top.sv
// Purpose: Self-checking bench of the turn-count reader.
// Assumes: Zero-wait AHB-Lite slave; short verify period and gap set by parameters.
// Notes: Expected values are worked out from the frame contents set here.
`timescale 1ns/1ps
`include "mts_cfg.svh"

module tb_top;
	import mts_pkg::*;

	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0000_0000;
	logic st_wrap_up = 1'b0;
	logic st_wrap_down = 1'b0;
	logic [3:0] st_position_msbs = 4'h0;
	logic slow = 1'b0;
	logic [31:0] sword = 32'h0000_0000;
	logic [5:0] slen = 6'h00;
	logic hready, hreadyout, hresp, ssi_clk, ssi_data, startup_done, irq;
	logic [31:0] hrdata;
	logic [31:0] rv;
	logic [23:0] turn_count;
	logic [5:0] st_extension;
	logic [2:0] st_extension_width;
	int err_total = 0;
	int n_checks = 0;
	int n_falls = 0;

	assign hready = hreadyout;
	always #5 hclk = ~hclk;
	always @(negedge ssi_clk) n_falls++;

	mts_sync #(.VERIFY_CYCLES(200), .GAP_CYCLES(20)) dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .st_wrap_up, .st_wrap_down, .st_position_msbs,
		.ssi_clk, .ssi_data, .turn_count, .st_extension, .st_extension_width, .startup_done, .irq);

	mts_sensor sensor_u (.hclk, .ssi_clk, .ssi_data, .slow, .word(sword), .len(slen));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic complete_run;
		$display("Checks %0d, errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : complete_run

	task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d, output logic [31:0] r);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {22'h0, a};
		hwrite <= w;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		r = hrdata;
	endtask : bus

	task automatic wrap(input logic u, input logic d);
		st_wrap_up <= u;
		st_wrap_down <= d;
		@(posedge hclk);
		st_wrap_up <= 1'b0;
		st_wrap_down <= 1'b0;
		repeat (3) @(posedge hclk);
	endtask : wrap

	// Waits for a frame to start, then for its bits, evaluation and update to pass.
	task automatic wframe(input int nb);
		int k;
		int f0;
		k = 0;
		f0 = n_falls;
		while (ssi_clk !== 1'b0 && k < 3000) begin
			@(posedge hclk);
			k++;
		end
		repeat (nb * 16 + 4) @(posedge hclk);
		check(32'(n_falls - f0), 32'(nb));
	endtask : wframe

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		logic [9:0] al [6];
		al = '{`MTS_ADDR_DIR, `MTS_ADDR_OFF, `MTS_ADDR_MODE, `MTS_ADDR_MASK, `MTS_ADDR_CNT, 10'h3FC};
		bus(1'b1, 10'h3FC, 32'hFFFF_FFFF, rv);
		foreach (al[i]) begin
			bus(1'b0, al[i], 32'h0, rv);
			check(rv, 32'h0);
		end
		bus(1'b1, `MTS_ADDR_DIR, 32'h0000_00E0, rv);
		bus(1'b0, `MTS_ADDR_DIR, 32'h0, rv);
		check(rv, 32'h0000_00E0);
		bus(1'b1, `MTS_ADDR_DIR, 32'h0, rv);
		check(32'(irq), 32'h0);
		check(32'(hresp), 32'h0);
		check(32'(hreadyout), 32'h1);
	endtask : t_reset

	task automatic t_mode0;
		repeat (3) wrap(1'b1, 1'b0);
		wrap(1'b0, 1'b1);
		wrap(1'b1, 1'b1);
		check(32'(turn_count), 32'h2);
		check(32'(startup_done), 32'h1);
		check(32'(n_falls), 32'h0);
		bus(1'b0, `MTS_ADDR_CNT, 32'h0, rv);
		check(rv, 32'h2);
	endtask : t_mode0

	task automatic t_startup;
		st_position_msbs <= 4'h4;
		sword <= {17'h0, 12'h123, 2'b01, 1'b0};
		slen <= 6'd15;
		slow <= 1'b1;
		bus(1'b1, `MTS_ADDR_DIR, 32'h0000_0040, rv);
		bus(1'b1, `MTS_ADDR_MODE, 32'h0000_001D, rv);
		wframe(15);
		check(32'(startup_done), 32'h0);
		sword <= {17'h0, 12'h122, 2'b11, 1'b1};
		st_position_msbs <= 4'h0;
		bus(1'b0, `MTS_ADDR_STAT, 32'h0, rv);
		check(rv & 32'h2, 32'h2);
		wframe(15);
		check(32'(startup_done), 32'h1);
		check(32'(turn_count), 32'h123);
		wrap(1'b1, 1'b0);
		check(32'(turn_count), 32'h124);
		wrap(1'b0, 1'b1);
		check(32'(turn_count), 32'h123);
	endtask : t_startup

	task automatic t_verify;
		bus(1'b1, `MTS_ADDR_STAT, 32'h7, rv);
		bus(1'b1, `MTS_ADDR_DIR, 32'h0000_0060, rv);
		bus(1'b1, `MTS_ADDR_OFF, 32'h0000_0010, rv);
		st_position_msbs <= 4'h4;
		sword <= {17'h0, ~(14'h48D - 14'h1), 1'b1};
		slow <= 1'b0;
		bus(1'b1, `MTS_ADDR_CMD, 32'h1, rv);
		wframe(15);
		bus(1'b0, `MTS_ADDR_STAT, 32'h0, rv);
		check(rv & 32'h3, 32'h0);
		sword <= {17'h0, ~(14'h489 - 14'h1), 1'b1};
		bus(1'b1, `MTS_ADDR_CMD, 32'h1, rv);
		wframe(15);
		bus(1'b0, `MTS_ADDR_STAT, 32'h0, rv);
		check(rv & 32'h1, 32'h1);
		check(32'(turn_count), 32'h123);
		@(posedge hclk);
		check(32'(irq), 32'h0);
		bus(1'b1, `MTS_ADDR_MASK, 32'h1, rv);
		@(posedge hclk);
		check(32'(irq), 32'h1);
		bus(1'b1, `MTS_ADDR_STAT, 32'h1, rv);
		@(posedge hclk);
		check(32'(irq), 32'h0);
	endtask : t_verify

	task automatic t_periodic;
		int f0;
		f0 = n_falls;
		repeat (600) @(posedge hclk);
		check(32'(n_falls - f0), 32'h0);
		bus(1'b1, `MTS_ADDR_STAT, 32'h7, rv);
		bus(1'b1, `MTS_ADDR_DIR, 32'h0000_00E0, rv);
		sword <= {17'h0, ~(14'h48D - 14'h1), 1'b1};
		bus(1'b1, `MTS_ADDR_MODE, 32'h0000_005D, rv);
		wframe(15);
		bus(1'b0, `MTS_ADDR_STAT, 32'h0, rv);
		check(rv & 32'h3, 32'h2);
		bus(1'b1, `MTS_ADDR_DIR, 32'h0000_00A0, rv);
		sword <= {18'h0, ~(14'h48D - 14'h1)};
		slen <= 6'd14;
		wframe(14);
		bus(1'b1, `MTS_ADDR_MODE, 32'h0000_001D, rv);
		bus(1'b0, `MTS_ADDR_STAT, 32'h0, rv);
		check(rv & 32'h1, 32'h0);
	endtask : t_periodic

	task automatic t_modes;
		logic [2:0] w;
		for (int m = 1; m < 16; m++) begin
			w = (m <= 6) ? 3'(m) : (m <= 10) ? 3'(m - 4) : 3'h0;
			bus(1'b1, `MTS_ADDR_MODE, 32'(m), rv);
			bus(1'b0, `MTS_ADDR_MODE, 32'h0, rv);
			check(rv, 32'(m));
			check(32'(st_extension_width), 32'(w));
			check(32'(st_extension), 32'(24'h123 & ((24'h1 << w) - 24'h1)));
		end
	endtask : t_modes

	// ----------------------------------------
	// Sequence and watchdog
	// ----------------------------------------
	initial begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset();
		t_mode0();
		t_startup();
		t_verify();
		t_periodic();
		t_modes();
		complete_run();
	end

	// The whole run needs well under a fifth of this span.
	initial begin
		#200_000;
		err_total++;
		$display("Error at %0t: watchdog expired", $time);
		complete_run();
	end
endmodule : tb_top
